// ### mfcd_pkg.sv
// Constants for the two-wire command decoder of the multi-function part.
// Assumes one core clock; bus lines and pins are sampled into it.
package mfcd_pkg;
  // Fixed address bits: plain default, adjust per system
  localparam logic [5:0] DEV_ADDR_HI = 6'h28;

  localparam logic [7:0] CMD_BIG_WR = 8'h01;
  localparam logic [7:0] CMD_BIG_RD = 8'h03;
  localparam logic [7:0] CMD_SW_WR = 8'h04;
  localparam logic [7:0] CMD_SW_RD = 8'h06;
  localparam logic [7:0] CMD_IP_RD = 8'h07;
  localparam logic [7:0] CMD_OP = 8'h08;
  localparam logic [7:0] CMD_PI = 8'h09;
  localparam logic [7:0] CMD_DIR = 8'h0A;
  localparam logic [7:0] CMD_CTRL = 8'h0B;
  localparam logic [7:0] CMD_ALT_RD = 8'h0C;
  localparam logic [7:0] CMD_EE2OP = 8'h0F;
  localparam logic [7:0] CMD_EE2PI = 8'h10;
  localparam logic [7:0] CMD_EE2DIR = 8'h11;
  localparam logic [7:0] CMD_IP2EE = 8'h12;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  localparam logic [7:0] OP_RST = 8'h00;
  localparam logic [7:0] PI_RST = 8'hF0;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SW_EE_INIT = 8'h00;

  localparam int CTRL_OVR_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int LAT_BIT = 7;
  localparam int SW_W = 5;

  localparam logic [1:0] BN_ADDR = 2'h0;
  localparam logic [1:0] BN_CMD = 2'h1;
  localparam logic [1:0] BN_WORD = 2'h2;
  localparam logic [1:0] BN_DATA = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  localparam int EW_TIME_US = 4000;
  localparam int CLK_MHZ = 100;
  localparam int EW_CW = 19;

  // Positions in the synchroniser vector
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_STRAP = 2;
  localparam int SY_WP = 3;
  localparam int SY_SEL = 4;
  localparam int SY_SWLO = 5;
  localparam int SY_IOLO = 6;
  localparam int SY_ALT = 7;
  localparam int SY_GPIO = 12;
  localparam int SY_W = 20;
  localparam logic [19:0] SY_RST = 20'h00063;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_MACK = 3'b100
  } mfcd_state_t;
endpackage

// ### mfcd_sync.sv
// Two-stage synchroniser for a vector of unrelated pin levels.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps
`default_nettype none
module mfcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } mfcd_sync_t;

  mfcd_sync_t sy_reg;
  mfcd_sync_t sy_next;

  always_comb begin
    sy_next.meta = d;
    sy_next.q = sy_reg.meta;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sy_reg <= {RST, RST};
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign q = sy_reg.q;
endmodule // mfcd_sync
`default_nettype wire

// ### mfcd_top.sv
// Two-wire slave command decoder with GPIO, selector and EEPROM stores.
// Assumes bus clock well below core clock; all pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module mfcd_top
  import mfcd_pkg::*;
#(
  parameter int unsigned EW_CYCLES = EW_TIME_US * CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_strap,
  input wire logic write_guard,
  input wire logic source_select,
  input wire logic switch_force_low_n,
  input wire logic gpio_force_low_n,
  input wire logic [4:0] alt_input_pins,
  input wire logic [7:0] gpio_in,
  output logic [7:0] gpio_out,
  output logic [7:0] gpio_oe,
  output logic [4:0] switch_out_pins,
  output logic latched_output_pin
);
  typedef struct packed {
    mfcd_state_t st;
    logic scl_d;
    logic sda_d;
    logic [3:0] cnt;
    logic [1:0] byte_no;
    logic rw;
    logic mack;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] wa;
    logic [4:0] alt_input_values;
    logic [7:0] output_port_reg;
    logic [7:0] polarity_invert_reg;
    logic [7:0] direction_reg;
    logic [7:0] selector_control_reg;
    logic sda_low;
    logic pend_big;
    logic pend_sw;
    logic [7:0] pend_addr;
    logic [7:0] pend_data;
    logic busy;
    logic [EW_CW-1:0] busy_cnt;
    logic [4:0] sw_out;
    logic lat_out;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
  } mfcd_reg_t;

  localparam mfcd_reg_t RST_VAL = '{
    st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1, cnt: 4'h0, byte_no: BN_ADDR,
    rw: 1'b0, mack: 1'b0, sh: 8'h00, cmd: 8'h00, wa: 8'h00,
    alt_input_values: 5'h00, output_port_reg: OP_RST,
    polarity_invert_reg: PI_RST, direction_reg: DIR_RST,
    selector_control_reg: CTRL_RST, sda_low: 1'b0, pend_big: 1'b0,
    pend_sw: 1'b0, pend_addr: 8'h00, pend_data: 8'h00, busy: 1'b0,
    busy_cnt: '0, sw_out: 5'h00, lat_out: 1'b0, gpio_out: 8'h00,
    gpio_oe: 8'hFF
  };

  mfcd_reg_t st_reg;
  mfcd_reg_t st_next;
  logic [SY_W-1:0] sy_q;
  logic [7:0] big_eeprom [0:255];
  // Nonvolatile stand-in: no reset, keeps its contents
  logic [7:0] switch_eeprom = SW_EE_INIT;

  logic scl_s, sda_s, strap_s, wp_s, sel_s, swlo_n_s, iolo_n_s;
  logic [4:0] alt_s;
  logic [7:0] gpio_s;
  logic rise, fall, start, stop, commit, sel_ee, decide;
  logic [6:0] my_addr;
  logic [7:0] input_port_reg;
  logic [7:0] rd_byte;

  mfcd_sync #(.W(SY_W), .RST(SY_RST)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({gpio_in, alt_input_pins, gpio_force_low_n, switch_force_low_n,
        source_select, write_guard, address_strap, sda_in, scl_pin}),
    .q(sy_q)
  );

  assign scl_s = sy_q[SY_SCL];
  assign sda_s = sy_q[SY_SDA];
  assign strap_s = sy_q[SY_STRAP];
  assign wp_s = sy_q[SY_WP];
  assign sel_s = sy_q[SY_SEL];
  assign swlo_n_s = sy_q[SY_SWLO];
  assign iolo_n_s = sy_q[SY_IOLO];
  assign alt_s = sy_q[SY_ALT+4:SY_ALT];
  assign gpio_s = sy_q[SY_GPIO+7:SY_GPIO];

  function automatic logic is_ee_cmd(input logic [7:0] c);
    is_ee_cmd = (c == CMD_BIG_WR) || (c == CMD_BIG_RD) || (c == CMD_SW_WR) ||
                (c == CMD_SW_RD) || (c == CMD_EE2OP) || (c == CMD_EE2PI) ||
                (c == CMD_EE2DIR) || (c == CMD_IP2EE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    my_addr = {DEV_ADDR_HI, strap_s};
    rise = scl_s && !st_reg.scl_d;
    fall = !scl_s && st_reg.scl_d;
    start = scl_s && st_reg.scl_d && !sda_s && st_reg.sda_d;
    stop = scl_s && st_reg.scl_d && sda_s && !st_reg.sda_d;
    commit = st_reg.busy && (st_reg.busy_cnt == EW_CW'(1));
    decide = (st_reg.st == ST_RX) && fall && (st_reg.cnt == BYTE_BITS);
    // Inversion only applies to pins set as inputs
    input_port_reg = gpio_s ^ (st_reg.polarity_invert_reg & st_reg.direction_reg);
    st_next.scl_d = scl_s;
    st_next.sda_d = sda_s;

    case (st_reg.cmd)
      CMD_BIG_RD: rd_byte = big_eeprom[st_reg.wa];
      CMD_SW_RD: rd_byte = switch_eeprom;
      CMD_IP_RD: rd_byte = input_port_reg;
      CMD_OP: rd_byte = st_reg.output_port_reg;
      CMD_PI: rd_byte = st_reg.polarity_invert_reg;
      CMD_DIR: rd_byte = st_reg.direction_reg;
      CMD_CTRL: rd_byte = st_reg.selector_control_reg;
      CMD_ALT_RD: rd_byte = {3'h0, st_reg.alt_input_values};
      default: rd_byte = IDLE_BYTE;
    endcase

    case (st_reg.st)
      ST_IDLE: begin
      end
      ST_RX: begin
        if (rise) begin
          st_next.sh = {st_reg.sh[6:0], sda_s};
          st_next.cnt = st_reg.cnt + 4'h1;
        end else if (decide) begin
          st_next.cnt = 4'h0;
          st_next.st = ST_ACK;
          st_next.sda_low = 1'b1;
          case (st_reg.byte_no)
            BN_ADDR: begin
              st_next.rw = st_reg.sh[0];
              if (st_reg.sh[7:1] != my_addr) begin
                st_next.st = ST_IDLE;
                st_next.sda_low = 1'b0;
              end else if (!st_reg.sh[0]) begin
                st_next.byte_no = BN_CMD;
              end
            end
            BN_CMD: begin
              st_next.cmd = st_reg.sh;
              if (is_ee_cmd(st_reg.sh) && st_reg.busy) begin
                st_next.st = ST_IDLE;
                st_next.sda_low = 1'b0;
              end
              if (st_reg.sh == CMD_ALT_RD) begin
                st_next.alt_input_values = alt_s;
              end
              st_next.byte_no = is_ee_cmd(st_reg.sh) ? BN_WORD : BN_DATA;
            end
            BN_WORD: begin
              st_next.wa = st_reg.sh;
              st_next.byte_no = BN_DATA;
              case (st_reg.cmd)
                CMD_EE2OP: st_next.output_port_reg = big_eeprom[st_reg.sh];
                CMD_EE2PI: st_next.polarity_invert_reg = big_eeprom[st_reg.sh];
                CMD_EE2DIR: st_next.direction_reg = big_eeprom[st_reg.sh];
                CMD_IP2EE: begin
                  if (!wp_s) begin
                    st_next.pend_big = 1'b1;
                    st_next.pend_addr = st_reg.sh;
                    st_next.pend_data = input_port_reg;
                  end
                end
                default: begin
                end
              endcase
            end
            default: begin
              // Write only happens with direction 0 and guard low
              case (st_reg.cmd)
                CMD_BIG_WR: begin
                  if (!wp_s) begin
                    st_next.pend_big = 1'b1;
                    st_next.pend_addr = st_reg.wa;
                    st_next.pend_data = st_reg.sh;
                  end
                end
                CMD_SW_WR: begin
                  if (!wp_s) begin
                    st_next.pend_sw = 1'b1;
                    st_next.pend_data = st_reg.sh;
                  end
                end
                CMD_OP: if (!wp_s) st_next.output_port_reg = st_reg.sh;
                CMD_PI: if (!wp_s) st_next.polarity_invert_reg = st_reg.sh;
                CMD_DIR: if (!wp_s) st_next.direction_reg = st_reg.sh;
                CMD_CTRL: if (!wp_s) st_next.selector_control_reg = st_reg.sh;
                default: begin
                end
              endcase
            end
          endcase
        end
      end
      ST_ACK: begin
        if (fall) begin
          st_next.sda_low = 1'b0;
          st_next.st = ST_RX;
          if (st_reg.rw) begin
            st_next.st = ST_TX;
            st_next.sh = rd_byte;
            st_next.sda_low = !rd_byte[7];
            if (st_reg.cmd == CMD_BIG_RD) st_next.wa = st_reg.wa + 8'h01;
          end
        end
      end
      ST_TX: begin
        if (fall) begin
          st_next.cnt = st_reg.cnt + 4'h1;
          if (st_reg.cnt == LAST_BIT) begin
            st_next.st = ST_MACK;
            st_next.sda_low = 1'b0;
          end else begin
            st_next.sh = {st_reg.sh[6:0], 1'b0};
            st_next.sda_low = !st_reg.sh[6];
          end
        end
      end
      ST_MACK: begin
        if (rise) st_next.mack = !sda_s;
        if (fall) begin
          st_next.cnt = 4'h0;
          st_next.st = ST_IDLE;
          if (st_reg.mack) begin
            st_next.st = ST_TX;
            st_next.sh = rd_byte;
            st_next.sda_low = !rd_byte[7];
            if (st_reg.cmd == CMD_BIG_RD) st_next.wa = st_reg.wa + 8'h01;
          end
        end
      end
      default: st_next.st = ST_IDLE;
    endcase

    if (start) begin
      st_next.st = ST_RX;
      st_next.cnt = 4'h0;
      st_next.byte_no = BN_ADDR;
      st_next.sda_low = 1'b0;
    end
    if (stop) begin
      st_next.st = ST_IDLE;
      st_next.sda_low = 1'b0;
    end

    // Program cycle only begins at stop so partial frames never commit
    if (stop && (st_reg.pend_big || st_reg.pend_sw) && !st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.busy_cnt = EW_CW'(EW_CYCLES);
    end else if (st_reg.busy) begin
      st_next.busy_cnt = st_reg.busy_cnt - EW_CW'(1);
      if (commit) begin
        st_next.busy = 1'b0;
        st_next.pend_big = 1'b0;
        st_next.pend_sw = 1'b0;
      end
    end

    // Outputs stay on the old stored value until the cycle completes
    sel_ee = st_reg.selector_control_reg[CTRL_OVR_BIT] ?
             st_reg.selector_control_reg[CTRL_SEL_BIT] : !sel_s;
    if (!swlo_n_s) begin
      st_next.sw_out = 5'h00;
    end else if (sel_ee) begin
      st_next.sw_out = switch_eeprom[SW_W-1:0];
    end else begin
      st_next.sw_out = alt_s;
    end
    if (sel_ee) begin
      st_next.lat_out = swlo_n_s && switch_eeprom[LAT_BIT];
    end

    st_next.gpio_oe = iolo_n_s ? ~st_reg.direction_reg : 8'hFF;
    st_next.gpio_out = iolo_n_s ? st_reg.output_port_reg : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage arrays carry no reset so contents survive it
  always_ff @(posedge core_clk) begin
    if (commit && st_reg.pend_big) big_eeprom[st_reg.pend_addr] <= st_reg.pend_data;
    if (commit && st_reg.pend_sw) switch_eeprom <= st_reg.pend_data;
  end

  assign sda_out = 1'b0;
  assign sda_oe = st_reg.sda_low;
  assign gpio_out = st_reg.gpio_out;
  assign gpio_oe = st_reg.gpio_oe;
  assign switch_out_pins = st_reg.sw_out;
  assign latched_output_pin = st_reg.lat_out;

  ////////////////////////////////////////////////////////////////////////////
  chk_gpio_force_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    !iolo_n_s |=> (gpio_oe == 8'hFF) && (gpio_out == 8'h00))
    else $error("gpio force-low not applied");

  chk_switch_force_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    !swlo_n_s |=> switch_out_pins == 5'h00)
    else $error("switch force-low not applied");

  chk_guard_blocks_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_reg.pend_big || st_reg.pend_sw) |-> !$past(wp_s))
    else $error("eeprom write taken while guarded");

  chk_cycle_after_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (stop && (st_reg.pend_big || st_reg.pend_sw) && !st_reg.busy)
    |=> st_reg.busy [*8] ##0 (st_reg.busy_cnt == EW_CW'(EW_CYCLES) - EW_CW'(7)))
    else $error("program cycle did not start after stop");

  chk_foreign_address: assert property (@(posedge core_clk) disable iff (sys_rst)
    (decide && st_reg.byte_no == BN_ADDR && st_reg.sh[7:1] != my_addr && !start && !stop)
    |=> (st_reg.st == ST_IDLE) && !sda_oe)
    else $error("foreign address acknowledged");

  chk_source_stored: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sel_ee && swlo_n_s) |=> switch_out_pins == $past(switch_eeprom[4:0]))
    else $error("stored data not selected");

  chk_source_alt: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!sel_ee && swlo_n_s) |=> switch_out_pins == $past(alt_s))
    else $error("alternate inputs not selected");

  chk_port_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (decide && st_reg.byte_no == BN_DATA && st_reg.cmd == CMD_OP && !wp_s && !start && !stop)
    |=> ##1 st_reg.output_port_reg == $past(st_reg.sh, 2))
    else $error("output port write lost");

  chk_outputs_after_reset: assert property (@(posedge core_clk)
    $fell(sys_rst) |-> (st_reg.direction_reg == 8'h00) && (gpio_oe == 8'hFF))
    else $error("gpio not outputs after reset");
endmodule // mfcd_top
`default_nettype wire

// ### mfcd_master.sv
// Bus master model for the two-wire command decoder bench.
// Assumes the bench ANDs its SDA drive with the device's pull-down.
`timescale 1ns/1ps
`default_nettype none
module mfcd_master (
  input wire logic core_clk,
  input wire logic sda_wire,
  output logic scl_drv,
  output logic sda_drv
);
  ////////////////////////////////////////////////////////////////////
  // Idle bus: both lines released to the pull-up, clock stands still
  initial begin
    scl_drv = 1'h1;
    sda_drv = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // One 80 ns bit; data set mid-low, sampled at the end of high
  task automatic bit_io(input logic b, output logic s);
    scl_drv <= 1'h0;
    tick(2);
    sda_drv <= b;
    tick(2);
    scl_drv <= 1'h1;
    tick(4);
    s = sda_wire;
  endtask

  // Repeated start raises SDA while SCL is low first
  task automatic start_cond(input logic rep);
    if (rep) begin
      scl_drv <= 1'h0;
      tick(2);
      sda_drv <= 1'h1;
      tick(2);
      scl_drv <= 1'h1;
      tick(4);
    end
    sda_drv <= 1'h0;
    tick(4);
  endtask

  task automatic stop_cond();
    scl_drv <= 1'h0;
    tick(2);
    sda_drv <= 1'h0;
    tick(2);
    scl_drv <= 1'h1;
    tick(4);
    sda_drv <= 1'h1;
    tick(8);
  endtask

  // Byte out MSB first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'h1, s);
    ack = ~s;
  endtask

  // Low on the ninth bit keeps the read going; last byte is NACKed
  task automatic rbyte(input logic last, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, q[i]);
    end
    bit_io(last, s);
  endtask
endmodule // mfcd_master
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the two-wire command decoder.
// Assumes a pull-up on SDA and a short program cycle parameter.
`timescale 1ns/1ps
`default_nettype none
module testbench import mfcd_pkg::*;;
  localparam int unsigned EW = 400;
  logic core_clk, sys_rst, address_strap, write_guard, source_select;
  logic switch_force_low_n, gpio_force_low_n, latched_output_pin;
  logic sda_out, sda_oe, scl_drv, sda_drv;
  logic [4:0] alt_input_pins, switch_out_pins;
  logic [7:0] gpio_in, gpio_out, gpio_oe;
  int miscompares, comparisons;
  wire sda_wire;
  // Open-drain wired AND of both parties
  assign sda_wire = (sda_oe ? sda_out : 1'h1) & sda_drv;

  mfcd_top #(.EW_CYCLES(EW)) i_mfcd_top (
    .core_clk,
    .sys_rst,
    .scl_pin(scl_drv),
    .sda_in(sda_wire),
    .sda_out,
    .sda_oe,
    .address_strap,
    .write_guard,
    .source_select,
    .switch_force_low_n,
    .gpio_force_low_n,
    .alt_input_pins,
    .gpio_in,
    .gpio_out,
    .gpio_oe,
    .switch_out_pins,
    .latched_output_pin
  );
  mfcd_master i_mfcd_master (.core_clk, .sda_wire, .scl_drv, .sda_drv);

  ////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole transaction; a refused command byte ends it with a stop
  task automatic tx(input logic [7:0] cmd, input int nb, input logic [7:0] b1,
      input logic [7:0] b2, input logic rd, output logic [7:0] q, output logic ca);
    logic a;
    q = 8'h00;
    i_mfcd_master.start_cond(1'h0);
    i_mfcd_master.wbyte({DEV_ADDR_HI, address_strap, 1'h0}, a);
    i_mfcd_master.wbyte(cmd, ca);
    if (ca && nb > 0) i_mfcd_master.wbyte(b1, a);
    if (ca && nb > 1) i_mfcd_master.wbyte(b2, a);
    if (ca && rd) begin
      i_mfcd_master.start_cond(1'h1);
      i_mfcd_master.wbyte({DEV_ADDR_HI, address_strap, 1'h1}, a);
      i_mfcd_master.rbyte(1'h1, q);
    end
    i_mfcd_master.stop_cond();
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] q;
    logic ca;
    tx(cmd, 1, d, 8'h00, 1'h0, q, ca);
  endtask

  task automatic rchk(input logic [7:0] cmd, input int nb, input logic [7:0] w,
      input logic [7:0] exp, input logic [7:0] m);
    logic [7:0] q;
    logic ca;
    tx(cmd, nb, w, 8'h00, 1'h1, q, ca);
    chk(q & m, exp & m);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(gpio_oe, 8'hFF);
    chk(gpio_out, OP_RST);
    rchk(CMD_PI, 0, 8'h00, PI_RST, 8'hFF);
    rchk(CMD_DIR, 0, 8'h00, DIR_RST, 8'hFF);
    rchk(CMD_CTRL, 0, 8'h00, CTRL_RST, 8'hFF);
  endtask

  task automatic t_addr();
    logic a;
    logic [7:0] ad;
    for (int i = 0; i < 2; i++) begin
      ad = i ? {DEV_ADDR_HI ^ 6'h20, address_strap, 1'h0} : {DEV_ADDR_HI, ~address_strap, 1'h0};
      i_mfcd_master.start_cond(1'h0);
      i_mfcd_master.wbyte(ad, a);
      i_mfcd_master.stop_cond();
      chk({7'h00, a}, 8'h00);
    end
    address_strap <= 1'h1;
    tick(8);
    rchk(CMD_PI, 0, 8'h00, PI_RST, 8'hFF);
    address_strap <= 1'h0;
    tick(8);
  endtask

  // Guarded write must be discarded even for port registers
  task automatic t_gpio();
    wr(CMD_OP, 8'h5A);
    chk(gpio_out, 8'h5A);
    wr(CMD_DIR, 8'h0F);
    chk(gpio_oe, 8'hF0);
    wr(CMD_PI, 8'h3C);
    gpio_in <= 8'hA5;
    write_guard <= 1'h1;
    wr(CMD_OP, 8'hFF);
    chk(gpio_out, 8'h5A);
    write_guard <= 1'h0;
    rchk(CMD_IP_RD, 0, 8'h00, 8'hA9, 8'hFF);
    rchk(CMD_OP, 0, 8'h00, 8'h5A, 8'hFF);
    rchk(CMD_PI, 0, 8'h00, 8'h3C, 8'hFF);
    rchk(CMD_DIR, 0, 8'h00, 8'h0F, 8'hFF);
    wr(CMD_DIR, DIR_RST);
    wr(CMD_PI, PI_RST);
  endtask

  task automatic t_switch();
    logic [7:0] q;
    logic ca;
    tx(CMD_SW_WR, 2, 8'h00, 8'h9A, 1'h0, q, ca);
    tx(CMD_SW_RD, 1, 8'h00, 8'h00, 1'h1, q, ca);
    chk({7'h00, ca}, 8'h00);
    tick(EW);
    rchk(CMD_SW_RD, 1, 8'h00, 8'h9A, 8'h9F);
    chk({3'h0, switch_out_pins}, 8'h1A);
    chk({7'h00, latched_output_pin}, 8'h01);
    alt_input_pins <= 5'h15;
    source_select <= 1'h1;
    tick(8);
    chk({3'h0, switch_out_pins}, 8'h15);
    chk({7'h00, latched_output_pin}, 8'h01);
    rchk(CMD_ALT_RD, 0, 8'h00, 8'h15, 8'h1F);
    switch_force_low_n <= 1'h0;
    tick(8);
    chk({3'h0, switch_out_pins}, 8'h00);
    switch_force_low_n <= 1'h1;
    wr(CMD_CTRL, 8'h03);
    chk({3'h0, switch_out_pins}, 8'h1A);
    wr(CMD_CTRL, 8'h01);
    chk({3'h0, switch_out_pins}, 8'h15);
    rchk(CMD_CTRL, 0, 8'h00, 8'h01, 8'h03);
    wr(CMD_CTRL, CTRL_RST);
    source_select <= 1'h0;
    write_guard <= 1'h1;
    tx(CMD_SW_WR, 2, 8'h00, 8'h00, 1'h0, q, ca);
    tick(EW);
    write_guard <= 1'h0;
    rchk(CMD_SW_RD, 1, 8'h00, 8'h9A, 8'h9F);
    sys_rst <= 1'h1;
    tick(8);
    sys_rst <= 1'h0;
    tick(8);
    chk({3'h0, switch_out_pins}, 8'h1A);
  endtask

  task automatic t_big();
    logic [7:0] q;
    logic ca;
    tx(CMD_BIG_WR, 2, 8'h10, 8'hC3, 1'h0, q, ca);
    tick(EW);
    rchk(CMD_BIG_RD, 1, 8'h10, 8'hC3, 8'hFF);
    wr(CMD_EE2OP, 8'h10);
    chk(gpio_out, 8'hC3);
    wr(CMD_EE2PI, 8'h10);
    rchk(CMD_PI, 0, 8'h00, 8'hC3, 8'hFF);
    wr(CMD_EE2DIR, 8'h10);
    rchk(CMD_DIR, 0, 8'h00, 8'hC3, 8'hFF);
    gpio_in <= 8'h5A;
    wr(CMD_IP2EE, 8'h20);
    tick(EW);
    rchk(CMD_BIG_RD, 1, 8'h20, 8'h99, 8'hFF);
    wr(CMD_DIR, DIR_RST);
    wr(CMD_PI, PI_RST);
  endtask

  // Master ack keeps a read going and the big store address steps on
  task automatic t_burst();
    logic a;
    logic [7:0] q;
    tx(CMD_BIG_WR, 2, 8'h11, 8'h3E, 1'h0, q, a);
    tick(EW);
    tx(CMD_BIG_RD, 1, 8'h10, 8'h00, 1'h0, q, a);
    i_mfcd_master.start_cond(1'h0);
    i_mfcd_master.wbyte({DEV_ADDR_HI, address_strap, 1'h1}, a);
    i_mfcd_master.rbyte(1'h0, q);
    chk(q, 8'hC3);
    i_mfcd_master.rbyte(1'h1, q);
    chk(q, 8'h3E);
    i_mfcd_master.stop_cond();
  endtask

  task automatic t_rsvd();
    logic [7:0] codes [4] = '{8'h0D, 8'h0E, 8'h13, 8'hFF};
    foreach (codes[i]) begin
      wr(codes[i], 8'h00);
      rchk(codes[i], 0, 8'h00, IDLE_BYTE, 8'hFF);
      chk(gpio_out, 8'hC3);
    end
  endtask

  task automatic t_io_low();
    wr(CMD_DIR, 8'h0F);
    gpio_force_low_n <= 1'h0;
    tick(8);
    chk(gpio_oe, 8'hFF);
    chk(gpio_out, 8'h00);
    gpio_force_low_n <= 1'h1;
    tick(8);
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Run needs about 15500 cycles; limit well beyond that
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    conclude();
  end

  initial begin
    sys_rst = 1'h1;
    address_strap = 1'h0;
    write_guard = 1'h0;
    source_select = 1'h0;
    switch_force_low_n = 1'h1;
    gpio_force_low_n = 1'h1;
    alt_input_pins = 5'h0A;
    gpio_in = 8'h00;
    miscompares = 0;
    comparisons = 0;
    tick(8);
    sys_rst <= 1'h0;
    tick(8);
    t_reset();
    t_addr();
    t_gpio();
    t_switch();
    t_big();
    t_burst();
    t_rsvd();
    t_io_low();
    conclude();
  end
endmodule // testbench
`default_nettype wire
